// ===== verification/interlock_status_indicator_logic_bench.sv
// self-checking bench for the interlock status indicator logic
`timescale 1ns/1ps
`default_nettype none
module interlock_status_indicator_logic_bench;
   import isl_pkg::*;
   localparam int HALF = 4;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        target_life_zero = 1'b0;
   logic        output_at_setpoint = 1'b0;
   logic        host_return = 1'b0;
   isl_reg_t    reg_mode = ISL_REG_POWER;
   logic [31:0] avs_readdata, rd;
   logic [31:0] seed = 32'h9cbd;
   logic [2:0]  lamp_interlock;
   logic        avs_waitrequest, irq, output_enable, lamp_target_life, alarm_sound;
   logic        lamp_overtemp, lamp_arc, lamp_output, lamp_setpoint, lamp_left_display;
   logic        lamp_off_key, lamp_on_key, lamp_power_reg, lamp_current_reg;
   wire logic   coolant_flow_interlock_in, chamber_pressure_interlock_in, aux_interlock_in;
   wire logic   interlock_common, panic_halt_button, programming_keyswitch_position;
   wire logic   lock_keyswitch_position, off_key, on_key, over_temp_in, arc_sense_in;
   int          n_fail = 0;
   int          n_compared = 0;
   int          ones, diff, m;
   wire logic [5:0] flash = {lamp_interlock, lamp_target_life, lamp_overtemp, lamp_off_key};
   always #4 ref_clk = ~ref_clk;
   isl_top #(.BLINK_HALF_CYC(HALF)) dut_u (.*);
   isl_panel_model pm_u (.*);
   task automatic complete_run();
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // waitrequest and read data are taken at the accepting edge, before that edge updates them
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 40);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         n_fail++;
         complete_run();
      end
   endtask
   task automatic settle();
      repeat (12) @(posedge ref_clk);
      #1;
   endtask
   // four blink periods: a flashing lamp is lit in exactly half the samples
   task automatic watch(input int idx);
      ones = 0;
      diff = 0;
      repeat (8 * HALF)
      begin
         @(posedge ref_clk);
         #1;
         ones += flash[idx];
         diff += flash[idx] !== lamp_off_key;
      end
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      check("left lamp", 32'h1, lamp_left_display);
      bus(1'b0, ISL_OFS_CTRL, 32'h0);
      check("ctrl", ISL_CTRL_RST, rd);
      bus(1'b0, ISL_OFS_MASK, 32'h0);
      check("mask", ISL_MASK_RST, rd);
      bus(1'b0, ISL_OFS_STATE, 32'h0);
      check("state", 32'h2, rd & 32'h3);
      bus(1'b0, ISL_OFS_EVENT, 32'h0);
      bus(1'b1, ISL_OFS_MASK, 32'h1f);
      bus(1'b1, 4'h2, 32'hff);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", 32'h0, rd);
      bus(1'b0, ISL_OFS_MASK, 32'h0);
      check("mask", 32'h1f, rd);
      for (int i = 0; i < 4; i++)
      begin
         pm_u.contacts(i == 0 ? 3'h7 : 3'h7 ^ (3'h1 << (i - 1)), i != 0);
         pm_u.press(0, 6);
         bus(1'b0, ISL_OFS_STATE, 32'h0);
         check("pending", 32'h1, rd[ISL_ST_PENDING]);
      end
      pm_u.contacts(3'h7, 1'b1);
      pm_u.press(0, 20);
      bus(1'b0, ISL_OFS_STATE, 32'h0);
      check("pending", 32'h0, rd[ISL_ST_PENDING]);
      watch(0);
      check("off lamp", 8 * HALF, ones);
      check("ilk lamps", 32'h7, lamp_interlock);
      pm_u.press(1, 6);
      check("on lamps", 32'h7, {output_enable, lamp_on_key, lamp_output});
      @(posedge ref_clk);
      output_at_setpoint <= 1'b1;
      settle();
      check("setpoint lamp", 32'h1, lamp_setpoint);
      watch(0);
      check("off lamp", 32'h0, ones);
      for (int j = 0; j < 6; j++)
      begin
         m = j < 3 ? j : xs() % 3;
         @(posedge ref_clk);
         reg_mode <= isl_reg_t'(m);
         settle();
         check("reg lamps", {m != 1, m != 0}, {lamp_power_reg, lamp_current_reg});
      end
      bus(1'b0, ISL_OFS_EVENT, 32'h0);
      pm_u.contacts(3'h6, 1'b1);
      settle();
      check("enable", 32'h0, output_enable);
      watch(3);
      check("ilk flash", 4 * HALF, ones);
      check("phase", 32'h0, diff);
      check("irq", 32'h1, irq);
      bus(1'b0, ISL_OFS_EVENT, 32'h0);
      check("loss event", 32'h1, rd[ISL_EV_ILK_LOSS]);
      bus(1'b0, ISL_OFS_EVENT, 32'h0);
      settle();
      check("event clear", 32'h0, {rd[30:0], irq});
      pm_u.contacts(3'h7, 1'b1);
      pm_u.press(0, 6);
      pm_u.press(1, 6);
      pm_u.drive(5, 1'b1);
      settle();
      check("enable", 32'h0, output_enable);
      watch(1);
      check("hot flash", 4 * HALF, ones);
      bus(1'b1, ISL_OFS_CTRL, 32'h1);
      watch(1);
      check("hot steady", 8 * HALF, ones);
      pm_u.drive(5, 1'b0);
      bus(1'b1, ISL_OFS_CTRL, 32'h2);
      pm_u.press(0, 6);
      pm_u.press(1, 6);
      pm_u.contacts(3'h3, 1'b1);
      settle();
      check("aux trip", 32'h0, {output_enable, lamp_interlock[2]});
      for (int k = 0; k < 4; k++)
      begin
         pm_u.contacts(3'h7, 1'b1);
         pm_u.press(0, 6);
         if (k == 0)
         begin
            @(posedge ref_clk);
            host_return <= 1'b1;
            @(posedge ref_clk);
            host_return <= 1'b0;
         end
         else
            pm_u.drive(k + 1, 1'b1);
         settle();
         bus(1'b0, ISL_OFS_STATE, 32'h0);
         check("pending", 32'h1, rd[ISL_ST_PENDING]);
         pm_u.drive(k + 1, 1'b0);
      end
      bus(1'b1, ISL_OFS_MASK, 32'h0);
      bus(1'b0, ISL_OFS_EVENT, 32'h0);
      @(posedge ref_clk);
      target_life_zero <= 1'b1;
      pm_u.drive(6, 1'b1);
      settle();
      check("alarm", 32'h2, {alarm_sound, irq});
      watch(2);
      check("target flash", 4 * HALF, ones);
      check("phase", 32'h0, diff);
      check("arc lamp", 32'h1, lamp_arc);
      bus(1'b0, ISL_OFS_EVENT, 32'h0);
      check("events", 32'h9, rd & 32'h9);
      complete_run();
   end
endmodule
`default_nettype wire

// ===== verification/isl_assertions.sv
// assertion checker bound to the indicator top
`timescale 1ns/1ps
`default_nettype none
module isl_checker
(
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rst,
   // watched inputs
   input wire logic              coolant_flow_interlock_in,
   input wire logic              aux_interlock_in,
   input wire logic              interlock_common,
   input wire logic              over_temp_in,
   input wire logic              arc_sense_in,
   input wire logic              target_life_zero,
   input wire isl_pkg::isl_reg_t reg_mode,
   // watched outputs
   input wire logic              output_enable,
   input wire logic              irq,
   input wire logic              alarm_sound,
   input wire logic              lamp_arc,
   input wire logic              lamp_output,
   input wire logic              lamp_setpoint,
   input wire logic              lamp_left_display,
   input wire logic              lamp_on_key,
   input wire logic              lamp_power_reg,
   input wire logic              lamp_current_reg
);
   import isl_pkg::*;
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   chk_left_lit: assert property (!$past(rst) && !$past(rst, 2) |-> lamp_left_display)
      else $error("left display lamp dark");
   chk_volt_both: assert property ((reg_mode == ISL_REG_VOLTAGE)[*5] |-> lamp_power_reg && lamp_current_reg)
      else $error("voltage mode lamps wrong");
   chk_power_only: assert property ((reg_mode == ISL_REG_POWER)[*5] |-> lamp_power_reg && !lamp_current_reg)
      else $error("power mode lamps wrong");
   chk_on_lamps: assert property (lamp_on_key == output_enable && lamp_output == output_enable)
      else $error("on lamps disagree with output");
   chk_set_dark: assert property (!output_enable[*3] |-> !lamp_setpoint)
      else $error("setpoint lamp lit while off");
   chk_ilk_trip: assert property ($fell(coolant_flow_interlock_in) |-> ##[1:10] !output_enable)
      else $error("coolant loss left output on");
   chk_aux_trip: assert property ($fell(aux_interlock_in) |-> ##[1:10] !output_enable)
      else $error("aux loss left output on");
   chk_hot_trip: assert property ($rose(over_temp_in) |-> ##[1:10] !output_enable)
      else $error("over temperature left output on");
   chk_arc_lit: assert property (arc_sense_in[*8] |-> lamp_arc)
      else $error("arc lamp dark");
   chk_alarm_on: assert property (target_life_zero[*5] |-> alarm_sound)
      else $error("alarm silent");
   chk_common_off: assert property (!interlock_common[*8] |-> ##2 !output_enable)
      else $error("output on with off input open");
   cov_on_off: cover property (output_enable ##1 !output_enable);
   cov_irq: cover property ($rose(irq));
   cov_arc: cover property ($rose(lamp_arc));
endmodule
bind isl_top isl_checker chk_u (.*);
`default_nettype wire

// ===== verification/isl_panel_model.sv
// keypad and process interlock contacts driven by the bench
`timescale 1ns/1ps
`default_nettype none
module isl_panel_model
(
   // clock
   input wire logic  ref_clk,
   // contacts and keys, high when closed or held
   output wire logic coolant_flow_interlock_in,
   output wire logic chamber_pressure_interlock_in,
   output wire logic aux_interlock_in,
   output wire logic interlock_common,
   output wire logic panic_halt_button,
   output wire logic programming_keyswitch_position,
   output wire logic lock_keyswitch_position,
   output wire logic off_key,
   output wire logic on_key,
   output wire logic over_temp_in,
   output wire logic arc_sense_in
);
   // 0 off, 1 on, 2 panic, 3 programming_keyswitch_position, 4 lock, 5 hot, 6 arc, 7-9 interlocks, 10 common
   logic [10:0] pins_r = 11'h780;
   assign {interlock_common, aux_interlock_in, chamber_pressure_interlock_in,
      coolant_flow_interlock_in, arc_sense_in, over_temp_in, lock_keyswitch_position,
      programming_keyswitch_position, panic_halt_button, on_key, off_key} = pins_r;
   task automatic drive(input int sel, input logic v);
      @(posedge ref_clk);
      pins_r[sel] <= v;
   endtask
   // contacts move together so no half-grounded mix is seen
   task automatic contacts(input logic [2:0] ilk, input logic com);
      @(posedge ref_clk);
      pins_r[10:7] <= {com, ilk};
   endtask
   // hold picks a prompt or a slow operator; the filter needs a few cycles
   task automatic press(input int sel, input int hold);
      drive(sel, 1'b1);
      repeat (hold) @(posedge ref_clk);
      drive(sel, 1'b0);
      repeat (12) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ===== verilog/isl_blink.sv
// shared blink phase generator
`timescale 1ns/1ps
`default_nettype none
module isl_blink
#(
   parameter int HALF_CYC = 31250000
)
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // square wave, high half the time
   output var  logic blink
);
   import isl_pkg::*;

   logic [31:0] cnt_r;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cnt_r <= 32'h0;
         blink <= 1'b0;
      end
      else if (cnt_r == 32'(HALF_CYC - 1))
      begin
         cnt_r <= 32'h0;
         blink <= ~blink;
      end
      else
      begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/isl_pkg.sv
// constants and types shared by the interlock status indicator logic
// Functional notes
// - target-life counter at zero flashes its lamp and sounds the alarm.
// - over-temperature forces output off and flashes its lamp on standard panels.
// - passive panel shows over-temperature steadily while it holds output off.
// - interlock lamp lights steadily once grounded and reset by output-off.
// - auxiliary interlock loss forces output off even without an auxiliary lamp.
// - passive arc lamp lights whenever an arc is sensed.
// - passive output lamp lights while output is on.
// - passive setpoint lamp lights while on and at setpoint, else dark.
// - left-display selection lamp is permanently lit.
// - output-off key lamp steady while output off, flashing while reset pending.
// - listed events (power-up, host return, mode key, off open, interlock, stop) need reset.
// - output-off key press clears pending reset; lamp stays lit.
// - reset request ignored while off input open or any interlock unmet.
// - output-on key lamp lit while output is on.
// - power lamp for power regulation, current lamp for current regulation.
// - voltage regulation lights both power and current lamps.
package isl_pkg;
   typedef enum logic [1:0] {ISL_REG_POWER, ISL_REG_CURRENT, ISL_REG_VOLTAGE} isl_reg_t;

   localparam int          ISL_CLK_HZ        = 125000000;
   localparam int          ISL_BLINK_HALF_MS = 250;
   localparam int          ISL_BLINK_HALF_CYC = ISL_CLK_HZ / 1000 * ISL_BLINK_HALF_MS;
   localparam int          ISL_SYNC_STAGES   = 3;
   localparam int          ISL_NUM_ILK       = 3;

   // register byte offsets
   localparam logic [3:0]  ISL_OFS_CTRL      = 4'h0;
   localparam logic [3:0]  ISL_OFS_STATE     = 4'h4;
   localparam logic [3:0]  ISL_OFS_EVENT     = 4'h8;
   localparam logic [3:0]  ISL_OFS_MASK      = 4'hc;

   // control fields
   localparam int          ISL_CTRL_PASSIVE  = 0;
   localparam int          ISL_CTRL_NO_AUX   = 1;
   localparam int          ISL_CTRL_W        = 2;
   localparam logic [1:0]  ISL_CTRL_RST      = 2'h0;

   // event fields (status and mask share the layout)
   localparam int          ISL_EV_TARGET     = 0;
   localparam int          ISL_EV_OVERTEMP   = 1;
   localparam int          ISL_EV_ILK_LOSS   = 2;
   localparam int          ISL_EV_ARC        = 3;
   localparam int          ISL_EV_PENDING    = 4;
   localparam int          ISL_EV_W          = 5;
   localparam logic [4:0]  ISL_MASK_RST      = 5'h00;

   // state fields
   localparam int          ISL_ST_OUT_ON     = 0;
   localparam int          ISL_ST_PENDING    = 1;
   localparam int          ISL_ST_OVERTEMP   = 2;
   localparam int          ISL_ST_ARMED      = 3;
   localparam int          ISL_ST_TRIPPED    = 6;
   localparam int          ISL_ST_W          = 9;
endpackage

// ===== verilog/isl_sync.sv
// three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module isl_sync
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // pins in, filtered levels out
   input  wire logic [W-1:0] pin_in,
   output var  logic [W-1:0] level_out
);
   import isl_pkg::*;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic [ISL_SYNC_STAGES-1:0] stage_r;
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               stage_r <= '0;
            end
            else
            begin
               stage_r <= {stage_r[ISL_SYNC_STAGES-2:0], pin_in[i]};
            end
         end
         // only the later two stages are compared; the first feeds the second alone
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               level_out[i] <= 1'b0;
            end
            else if (stage_r[1] == stage_r[2])
            begin
               level_out[i] <= stage_r[2];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ===== verilog/isl_top.sv
// front-panel status, interlock and reset-pending logic with avalon register slave
`timescale 1ns/1ps
`default_nettype none
module isl_top
#(
   parameter int BLINK_HALF_CYC = isl_pkg::ISL_BLINK_HALF_CYC,
   parameter int NUM_ILK        = isl_pkg::ISL_NUM_ILK
)
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // avalon-mm slave
   input  wire logic [3:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output var  logic [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   output var  logic                 irq,
   // pins: high means contact closed or key held
   input  wire logic                 coolant_flow_interlock_in,
   input  wire logic                 chamber_pressure_interlock_in,
   input  wire logic                 aux_interlock_in,
   input  wire logic                 interlock_common,
   input  wire logic                 panic_halt_button,
   input  wire logic                 programming_keyswitch_position,
   input  wire logic                 lock_keyswitch_position,
   input  wire logic                 off_key,
   input  wire logic                 on_key,
   input  wire logic                 over_temp_in,
   input  wire logic                 arc_sense_in,
   // internal status on this clock
   input  wire logic                 target_life_zero,
   input  wire logic                 output_at_setpoint,
   input  wire logic                 host_return,
   input  wire isl_pkg::isl_reg_t    reg_mode,
   // output-enable path
   output var  logic                 output_enable,
   // lamps and alarm
   output var  logic                 lamp_target_life,
   output var  logic                 alarm_sound,
   output var  logic                 lamp_overtemp,
   output var  logic [NUM_ILK-1:0]   lamp_interlock,
   output var  logic                 lamp_arc,
   output var  logic                 lamp_output,
   output var  logic                 lamp_setpoint,
   output var  logic                 lamp_left_display,
   output var  logic                 lamp_off_key,
   output var  logic                 lamp_on_key,
   output var  logic                 lamp_power_reg,
   output var  logic                 lamp_current_reg
);
   import isl_pkg::*;

   localparam int NPIN = NUM_ILK + 8;

   logic [NPIN-1:0]          pin_raw;
   logic [NPIN-1:0]          pin_lvl;
   logic [NUM_ILK-1:0]       ilk_in;
   logic                     common_ok;
   logic                     panic;
   logic                     programming_keyswitch_position_pos;
   logic                     lock_pos;
   logic                     off_lvl;
   logic                     on_lvl;
   logic                     hot;
   logic                     arc;
   logic                     blink;

   logic                     off_prev_r;
   logic                     on_prev_r;
   logic                     mode_off_r;
   logic                     off_press;
   logic                     on_press;
   logic                     mode_armed;

   logic [NUM_ILK-1:0]       armed_r;
   logic [NUM_ILK-1:0]       tripped_r;
   logic [NUM_ILK-1:0]       ilk_loss;
   logic                     ilk_all_ok;
   logic                     reset_ok;
   logic                     reset_take;
   logic                     pending_r;
   logic                     pending_set;
   logic                     overtemp_r;
   logic                     out_on_r;
   logic                     force_off;

   logic [ISL_CTRL_W-1:0]    ctrl_r;
   logic [ISL_EV_W-1:0]      event_r;
   logic [ISL_EV_W-1:0]      event_nxt;
   logic [ISL_EV_W-1:0]      event_in;
   logic [ISL_EV_W-1:0]      mask_r;
   logic                     arc_prev_r;
   logic                     tl_prev_r;
   logic                     pend_prev_r;
   logic                     ack_r;
   logic                     acc;
   logic                     passive;
   logic [ISL_ST_W-1:0]      state_vec;

   assign pin_raw = {aux_interlock_in, chamber_pressure_interlock_in, coolant_flow_interlock_in,
                     interlock_common, panic_halt_button, programming_keyswitch_position,
                     lock_keyswitch_position, off_key, on_key, over_temp_in, arc_sense_in};

   isl_sync #(.W(NPIN)) u_sync
   (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .pin_in    (pin_raw),
      .level_out (pin_lvl)
   );

   isl_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .blink   (blink)
   );

   assign arc       = pin_lvl[0];
   assign hot       = pin_lvl[1];
   assign on_lvl    = pin_lvl[2];
   assign off_lvl   = pin_lvl[3];
   assign lock_pos  = pin_lvl[4];
   assign programming_keyswitch_position_pos  = pin_lvl[5];
   assign panic     = pin_lvl[6];
   assign common_ok = pin_lvl[7];
   assign ilk_in    = pin_lvl[NPIN-1:8];
   assign passive   = ctrl_r[ISL_CTRL_PASSIVE];

   // key edges and mode key position
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         off_prev_r <= 1'b0;
         on_prev_r  <= 1'b0;
         mode_off_r <= 1'b1;
      end
      else
      begin
         off_prev_r <= off_lvl;
         on_prev_r  <= on_lvl;
         mode_off_r <= ~(programming_keyswitch_position_pos | lock_pos);
      end
   end

   assign off_press  = off_lvl & ~off_prev_r;
   assign on_press   = on_lvl & ~on_prev_r;
   // mode_off_r starts set, so power-up in lock or program also counts as a move
   assign mode_armed = mode_off_r & (programming_keyswitch_position_pos | lock_pos);

   assign ilk_all_ok = &ilk_in;
   assign reset_ok   = common_ok & ilk_all_ok;
   assign reset_take = off_press & reset_ok;

   // per-interlock armed and tripped state
   genvar g;
   generate
      for (g = 0; g < NUM_ILK; g++)
      begin : g_ilk
         assign ilk_loss[g] = armed_r[g] & ~ilk_in[g];
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               armed_r[g]   <= 1'b0;
               tripped_r[g] <= 1'b0;
            end
            else if (ilk_loss[g])
            begin
               armed_r[g]   <= 1'b0;
               tripped_r[g] <= 1'b1;
            end
            else if (reset_take)
            begin
               armed_r[g]   <= 1'b1;
               tripped_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign pending_set = mode_armed | host_return | ~common_ok | ~ilk_all_ok | panic;

   // set wins over the clearing key press
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pending_r <= 1'b1;
      end
      else if (pending_set)
      begin
         pending_r <= 1'b1;
      end
      else if (reset_take)
      begin
         pending_r <= 1'b0;
      end
   end

   // over-temperature latch holds output off until a reset while cool
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         overtemp_r <= 1'b0;
      end
      else if (hot)
      begin
         overtemp_r <= 1'b1;
      end
      else if (reset_take)
      begin
         overtemp_r <= 1'b0;
      end
   end

   // aux loss trips output whatever panel is fitted
   assign force_off = hot | overtemp_r | (|ilk_loss) | ~ilk_all_ok | panic | ~common_ok;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         out_on_r <= 1'b0;
      end
      else if (force_off | off_press | pending_set)
      begin
         out_on_r <= 1'b0;
      end
      else if (on_press & ~pending_r)
      begin
         out_on_r <= 1'b1;
      end
   end

   // lamps, registered so they stand glitch-free at the pins
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         output_enable     <= 1'b0;
         lamp_target_life  <= 1'b0;
         alarm_sound       <= 1'b0;
         lamp_overtemp     <= 1'b0;
         lamp_interlock    <= '0;
         lamp_arc          <= 1'b0;
         lamp_output       <= 1'b0;
         lamp_setpoint     <= 1'b0;
         lamp_left_display <= 1'b0;
         lamp_off_key      <= 1'b0;
         lamp_on_key       <= 1'b0;
         lamp_power_reg    <= 1'b0;
         lamp_current_reg  <= 1'b0;
      end
      else
      begin
         output_enable     <= out_on_r;
         lamp_target_life  <= target_life_zero & blink;
         alarm_sound       <= target_life_zero;
         lamp_overtemp     <= overtemp_r & (passive | blink);
         for (int i = 0; i < NUM_ILK; i++)
         begin
            lamp_interlock[i] <= tripped_r[i] ? blink : armed_r[i];
         end
         if (ctrl_r[ISL_CTRL_NO_AUX])
         begin
            lamp_interlock[NUM_ILK-1] <= 1'b0;
         end
         lamp_arc          <= arc;
         lamp_output       <= out_on_r;
         lamp_setpoint     <= out_on_r & output_at_setpoint;
         lamp_left_display <= 1'b1;
         lamp_off_key      <= pending_r ? blink : ~out_on_r;
         lamp_on_key       <= out_on_r;
         lamp_power_reg    <= (reg_mode == ISL_REG_POWER) | (reg_mode == ISL_REG_VOLTAGE);
         lamp_current_reg  <= (reg_mode == ISL_REG_CURRENT) | (reg_mode == ISL_REG_VOLTAGE);
      end
   end

   // rising-edge events for the interrupt status
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         arc_prev_r  <= 1'b0;
         tl_prev_r   <= 1'b0;
         pend_prev_r <= 1'b0;
      end
      else
      begin
         arc_prev_r  <= arc;
         tl_prev_r   <= target_life_zero;
         pend_prev_r <= pending_r;
      end
   end

   always_comb
   begin
      event_in                  = '0;
      event_in[ISL_EV_TARGET]   = target_life_zero & ~tl_prev_r;
      event_in[ISL_EV_OVERTEMP] = hot & ~overtemp_r;
      event_in[ISL_EV_ILK_LOSS] = |ilk_loss;
      event_in[ISL_EV_ARC]      = arc & ~arc_prev_r;
      event_in[ISL_EV_PENDING]  = pending_r & ~pend_prev_r;
   end

   // slave: one wait cycle, answer on the second
   assign acc             = (avs_read | avs_write) & ack_r;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   // a read of the event register clears it, but new events win
   always_comb
   begin
      event_nxt = event_r;
      if (acc & avs_read & (avs_address == ISL_OFS_EVENT))
      begin
         event_nxt = '0;
      end
      event_nxt = event_nxt | event_in;
   end

   assign state_vec = {tripped_r, armed_r, overtemp_r, pending_r, out_on_r};

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         event_r <= '0;
         irq     <= 1'b0;
      end
      else
      begin
         event_r <= event_nxt;
         irq     <= |(event_nxt & mask_r);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_r <= ISL_CTRL_RST;
         mask_r <= ISL_MASK_RST;
      end
      else if (acc & avs_write & avs_byteenable[0])
      begin
         if (avs_address == ISL_OFS_CTRL)
         begin
            ctrl_r <= avs_writedata[ISL_CTRL_W-1:0];
         end
         else if (avs_address == ISL_OFS_MASK)
         begin
            mask_r <= avs_writedata[ISL_EV_W-1:0];
         end
      end
   end

   // read data is loaded in the wait cycle and stands at the accepting edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         avs_readdata <= 32'h0;
      end
      else if (avs_read & ~ack_r)
      begin
         if (avs_address == ISL_OFS_CTRL)
         begin
            avs_readdata <= 32'(ctrl_r);
         end
         else if (avs_address == ISL_OFS_STATE)
         begin
            avs_readdata <= 32'(state_vec);
         end
         else if (avs_address == ISL_OFS_EVENT)
         begin
            avs_readdata <= 32'(event_r | event_in);
         end
         else if (avs_address == ISL_OFS_MASK)
         begin
            avs_readdata <= 32'(mask_r);
         end
         else
         begin
            avs_readdata <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire
